// file: rtl/geo_event_gpio.sv
// general-purpose open-drain pins with event-driven outputs and fault inputs
`timescale 1ns/10ps

// Summary of operation
// - eight open-drain pins; 1-4 trigger events, 5-6 event outputs, 7-8 plain
// - direction bit 1 makes the pin an output, 0 an input
// - polarity bit 1 means active high, 0 active low
// - input pin status is read-only and shows the asserted level
// - output pin status is writable and drives the asserted level
// - mask bit stops a pin status from reaching the interrupt
// - output pins are masked from the interrupt automatically
// - any of pins 1-4 can latch either event output; one mask each
// - mask bits 3..0 exclude pins 4..1; output takes OR of the rest
// - mask bits 7,6,5 gate voltage, temperature, fan fail; 1 ignores
// - enabled event drives output to its polarity, held if latch set
// - overheat inputs set status bits in host and management copies
// - overheat input forces fans full speed when enabled in config 2
// - mask register blocks overheat inputs from the warning output
// - termination inputs recorded in status bits 4 and 5, both copies
// - mask register blocks termination inputs from the warning output
// - rising intrusion input latches status bit 7 and interrupts
// - intrusion bit held until clear bit written 1; software then writes 0
// - intrusion monitoring off while backup cell reads below its limit
// - intrusion latched during power off interrupts only once powered
// - behaviour registers: pins 1-4 low, 5-8 high, direction odd bits
module geo_event_gpio
  import geo_pkg::*;
#(
  parameter int NUM_PINS = GEO_PINS,
  parameter int SYNC_STAGES = GEO_SYNC_STAGES
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [NUM_PINS-1:0] gpio_in,
  output logic [NUM_PINS-1:0] gpio_out,
  output logic [NUM_PINS-1:0] gpio_oe,
  input wire logic [GEO_AW-1:0] reg_addr,
  input wire logic [GEO_DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [GEO_DW-1:0] reg_rdata,
  input wire logic [1:0] regulator_overheat_input,
  input wire logic [1:0] bus_termination_input,
  input wire logic chassis_intrusion,
  input wire logic voltage_event,
  input wire logic overtemp_event,
  input wire logic fan_fail_event,
  input wire logic [GEO_NUM_EDO-1:0] event_latch_en,
  input wire logic [7:0] backup_cell_voltage,
  input wire logic [7:0] backup_cell_low_limit,
  input wire logic main_power_on,
  output logic int_out,
  output logic alert_out,
  output logic fan_full_speed,
  output logic [GEO_NUM_EDO-1:0] edo_active
);

  localparam int NIN = NUM_PINS + 5;

  if (NUM_PINS != GEO_PINS) begin : g_chk_pins
    $error("pin count must be eight");
  end
  if (SYNC_STAGES < 2) begin : g_chk_sync
    $error("synchroniser needs at least two stages");
  end

  logic [7:0] pin_config_2_r;
  logic [7:0] pin_config_3_r;
  logic [7:0] pin_behaviour_low_r;
  logic [7:0] pin_behaviour_high_r;
  logic [7:0] edo_enable_r;
  logic [7:0] overheat_input_mask_r;
  logic [7:0] termination_input_mask_r;
  logic [7:0] event_output_mask_a_r;
  logic [7:0] event_output_mask_b_r;
  logic [NUM_PINS-1:0] out_stat_r;
  logic [1:0] ovh_host_r;
  logic [1:0] ovh_mgmt_r;
  logic [1:0] term_host_r;
  logic [1:0] term_mgmt_r;
  logic ci_prev_r;
  logic ci_latched_r;
  logic [GEO_NUM_EDO-1:0] edo_act_r;
  logic [NIN-1:0] sync_r [SYNC_STAGES];

  logic [NIN-1:0] sync_out;
  logic [NUM_PINS-1:0] pin_lvl;
  logic [1:0] ovh_s;
  logic [1:0] term_s;
  logic ci_s;
  logic [2*NUM_PINS-1:0] bhv_all;
  logic [NUM_PINS-1:0] pin_dir;
  logic [NUM_PINS-1:0] pin_pol;
  logic [NUM_PINS-1:0] pin_asserted;
  logic [NUM_PINS-1:0] status_view;
  logic [NUM_PINS-1:0] eff_mask;
  logic pin_int;
  logic ci_mon_en;
  logic ci_rise;
  logic [GEO_NUM_EDO-1:0] edo_trig;
  logic [7:0] emask [GEO_NUM_EDO];
  logic [NUM_PINS-1:0] oe_nxt;
  logic [GEO_DW-1:0] rd_mux;
  logic wr_hit_pstat;

  // first stage feeds only the next stage
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      // pins idle high through their pull-ups; a zero here would look
      // like an asserted active-low input right after reset
      for (int i = 0; i < SYNC_STAGES; i++) begin
        sync_r[i] <= {5'b0_0000, {NUM_PINS{1'b1}}};
      end
    end else begin
      sync_r[0] <= {chassis_intrusion, bus_termination_input,
                    regulator_overheat_input, gpio_in};
      for (int i = 1; i < SYNC_STAGES; i++) begin
        sync_r[i] <= sync_r[i-1];
      end
    end
  end

  assign sync_out = sync_r[SYNC_STAGES-1];
  assign pin_lvl = sync_out[NUM_PINS-1:0];
  assign ovh_s = sync_out[NUM_PINS+1:NUM_PINS];
  assign term_s = sync_out[NUM_PINS+3:NUM_PINS+2];
  assign ci_s = sync_out[NUM_PINS+4];

  // per pin: polarity in even bit, direction in odd bit
  assign bhv_all = {pin_behaviour_high_r, pin_behaviour_low_r};
  for (genvar k = 0; k < NUM_PINS; k++) begin : g_pin
    assign pin_dir[k] = bhv_all[2*k+1];
    assign pin_pol[k] = bhv_all[2*k];
    assign pin_asserted[k] = (pin_lvl[k] == pin_pol[k]);
  end

  // input pins show live assertion, output pins show stored value
  assign status_view = (pin_dir & out_stat_r) |
                       (~pin_dir & pin_asserted);
  assign eff_mask = event_output_mask_b_r | pin_dir;
  assign pin_int = |(status_view & ~eff_mask);
  assign wr_hit_pstat = reg_wr && (reg_addr == ADDR_PIN_STATUS);

  // configuration registers
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pin_config_2_r <= RST_PIN_CONFIG_2;
      pin_config_3_r <= RST_PIN_CONFIG_3;
      pin_behaviour_low_r <= RST_PIN_BHV;
      pin_behaviour_high_r <= RST_PIN_BHV;
      edo_enable_r <= RST_EDO_ENABLE;
    end else if (reg_wr) begin
      case (reg_addr)
        ADDR_PIN_CONFIG_2: pin_config_2_r <= reg_wdata;
        ADDR_PIN_CONFIG_3: pin_config_3_r <= reg_wdata;
        ADDR_PIN_BHV_LOW: pin_behaviour_low_r <= reg_wdata;
        ADDR_PIN_BHV_HIGH: pin_behaviour_high_r <= reg_wdata;
        ADDR_EDO_ENABLE: edo_enable_r <= reg_wdata;
        default: ;
      endcase
    end
  end

  // mask registers
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      overheat_input_mask_r <= RST_MASK;
      termination_input_mask_r <= RST_MASK;
      event_output_mask_a_r <= RST_MASK;
      event_output_mask_b_r <= RST_MASK;
    end else if (reg_wr) begin
      case (reg_addr)
        ADDR_OVH_MASK: overheat_input_mask_r <= reg_wdata;
        ADDR_TERM_MASK: termination_input_mask_r <= reg_wdata;
        ADDR_EMASK_A: event_output_mask_a_r <= reg_wdata;
        ADDR_EMASK_B: event_output_mask_b_r <= reg_wdata;
        default: ;
      endcase
    end
  end

  // only output pins take written data; input bits stay read-only
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      out_stat_r <= '0;
    end else if (wr_hit_pstat) begin
      out_stat_r <= (reg_wdata & pin_dir) | (out_stat_r & ~pin_dir);
    end
  end

  // fault status copies: set wins over the clear-on-read of each copy
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ovh_host_r <= '0;
      ovh_mgmt_r <= '0;
      term_host_r <= '0;
      term_mgmt_r <= '0;
    end else begin
      ovh_host_r <= ovh_s |
        (ovh_host_r & {2{~(reg_rd && reg_addr == ADDR_HOST_TS2)}});
      ovh_mgmt_r <= ovh_s |
        (ovh_mgmt_r & {2{~(reg_rd && reg_addr == ADDR_MGMT_TS2)}});
      term_host_r <= term_s |
        (term_host_r & {2{~(reg_rd && reg_addr == ADDR_HOST_DS1)}});
      term_mgmt_r <= term_s |
        (term_mgmt_r & {2{~(reg_rd && reg_addr == ADDR_MGMT_DS1)}});
    end
  end

  // intrusion: the cell must be healthy for a detection to count
  assign ci_mon_en = (backup_cell_voltage >= backup_cell_low_limit);
  assign ci_rise = ci_s && !ci_prev_r;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ci_prev_r <= 1'b0;
      ci_latched_r <= 1'b0;
    end else begin
      ci_prev_r <= ci_s;
      if (ci_rise && ci_mon_en) begin
        ci_latched_r <= 1'b1;
      end else if (pin_config_3_r[CFG3_CI_CLEAR_BIT]) begin
        ci_latched_r <= 1'b0;
      end
    end
  end

  // event-driven outputs
  assign emask[0] = event_output_mask_a_r;
  assign emask[1] = event_output_mask_b_r;
  for (genvar j = 0; j < GEO_NUM_EDO; j++) begin : g_edo
    assign edo_trig[j] =
      |(pin_asserted[GEO_EVT_PINS-1:0] & ~emask[j][GEO_EVT_PINS-1:0]) |
      (voltage_event && !emask[j][EMASK_VOLT_BIT]) |
      (overtemp_event && !emask[j][EMASK_OVERHEAT_PIN_BIT]) |
      (fan_fail_event && !emask[j][EMASK_FAN_BIT]);
  end

  // without latch the output follows its events
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      edo_act_r <= '0;
    end else begin
      for (int j = 0; j < GEO_NUM_EDO; j++) begin
        if (event_latch_en[j]) begin
          edo_act_r[j] <= edo_act_r[j] | edo_trig[j];
        end else begin
          edo_act_r[j] <= edo_trig[j];
        end
      end
    end
  end

  // open drain: enable means pull low
  always_comb begin
    oe_nxt = '0;
    for (int k = 0; k < NUM_PINS; k++) begin
      if (pin_dir[k]) begin
        oe_nxt[k] = out_stat_r[k] ^ pin_pol[k];
      end
    end
    // event function overrides the direction of its pin
    for (int j = 0; j < GEO_NUM_EDO; j++) begin
      if (edo_enable_r[EDO_EN_LSB + j]) begin
        oe_nxt[EDO_PIN_LSB + j] =
          edo_act_r[j] ^ pin_pol[EDO_PIN_LSB + j];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      gpio_oe <= '0;
      gpio_out <= '0;
      edo_active <= '0;
    end else begin
      gpio_oe <= oe_nxt;
      gpio_out <= '0;
      edo_active <= edo_act_r;
    end
  end

  // interrupt, warning and fan boost
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      int_out <= 1'b0;
      alert_out <= 1'b0;
      fan_full_speed <= 1'b0;
    end else begin
      int_out <= pin_int || (ci_latched_r && main_power_on);
      alert_out <=
        |(ovh_host_r & ~overheat_input_mask_r[OVH_MASK_LSB +: 2]) |
        |(term_host_r & ~termination_input_mask_r[TERM_MASK_LSB +: 2]);
      fan_full_speed <=
        |(ovh_s & pin_config_2_r[CFG2_BOOST0_BIT +: 2]);
    end
  end

  // register read
  always_comb begin
    rd_mux = RST_ZERO;
    case (reg_addr)
      ADDR_PIN_CONFIG_2: rd_mux = pin_config_2_r;
      ADDR_PIN_CONFIG_3: rd_mux = pin_config_3_r;
      ADDR_PIN_BHV_LOW: rd_mux = pin_behaviour_low_r;
      ADDR_PIN_BHV_HIGH: rd_mux = pin_behaviour_high_r;
      ADDR_EDO_ENABLE: rd_mux = edo_enable_r;
      ADDR_OVH_MASK: rd_mux = overheat_input_mask_r;
      ADDR_TERM_MASK: rd_mux = termination_input_mask_r;
      ADDR_EMASK_A: rd_mux = event_output_mask_a_r;
      ADDR_EMASK_B: rd_mux = event_output_mask_b_r;
      ADDR_HOST_TS2: rd_mux[TS2_OVH_LSB +: 2] = ovh_host_r;
      ADDR_MGMT_TS2: rd_mux[TS2_OVH_LSB +: 2] = ovh_mgmt_r;
      ADDR_HOST_DS1: begin
        rd_mux[DS1_TERM_LSB +: 2] = term_host_r;
        rd_mux[DS1_CI_BIT] = ci_latched_r;
      end
      ADDR_MGMT_DS1: begin
        rd_mux[DS1_TERM_LSB +: 2] = term_mgmt_r;
        rd_mux[DS1_CI_BIT] = ci_latched_r;
      end
      ADDR_PIN_STATUS: rd_mux = status_view;
      default: rd_mux = RST_ZERO;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      reg_rdata <= RST_ZERO;
    end else if (reg_rd) begin
      reg_rdata <= rd_mux;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  a_input_status_follow: assert property (
    (gpio_in[7] && pin_pol[7] && !pin_dir[7])[*3] |-> status_view[7])
    else $error("input pin status does not follow asserted pin");

  a_output_auto_mask: assert property (
    (pin_dir == '1 && !ci_latched_r) |=> !int_out)
    else $error("output pin status raised an interrupt");

  a_unmasked_int: assert property (
    (status_view[7] && !pin_dir[7] && !event_output_mask_b_r[7])
      |=> int_out)
    else $error("unmasked input status did not interrupt");

  a_output_drive_low: assert property (
    (pin_dir[7] && out_stat_r[7] && !pin_pol[7]) |=> gpio_oe[7])
    else $error("asserted active-low output not driven");

  a_edo_latch_hold: assert property (
    (edo_act_r[0] && event_latch_en[0]) |=> edo_act_r[0])
    else $error("latched event output released");

  a_edo_all_ignored: assert property (
    (event_output_mask_a_r == EMASK_ALL_IGNORE && !event_latch_en[0])
      |=> !edo_act_r[0])
    else $error("fully masked event output became active");

  a_ci_latch_set: assert property (
    (ci_rise && ci_mon_en) |=> ci_latched_r)
    else $error("intrusion rise not latched");

  a_ci_clear: assert property (
    (ci_latched_r && pin_config_3_r[CFG3_CI_CLEAR_BIT] && !ci_rise)
      |=> !ci_latched_r)
    else $error("intrusion clear ignored");

  a_ci_power_gate: assert property (
    (ci_latched_r && !main_power_on && !pin_int) |=> !int_out)
    else $error("intrusion interrupt while unpowered");

  a_fan_boost: assert property (
    (regulator_overheat_input[0] && pin_config_2_r[CFG2_BOOST0_BIT])[*4]
      |-> fan_full_speed)
    else $error("overheat input did not boost fans");

  a_ovh_copies: assert property (
    regulator_overheat_input[0][*4] |-> ovh_host_r[0] && ovh_mgmt_r[0])
    else $error("overheat status copies not set");

  a_ovh_alert: assert property (
    (ovh_host_r[0] && !overheat_input_mask_r[OVH_MASK_LSB]) |=> alert_out)
    else $error("unmasked overheat did not warn");

endmodule // geo_event_gpio

// file: include/geo_pkg.sv
// shared constants for the event-driven general-purpose pin block
package geo_pkg;
  localparam int GEO_AW = 8;
  localparam int GEO_DW = 8;
  localparam int GEO_PINS = 8;
  localparam int GEO_EVT_PINS = 4;
  localparam int GEO_NUM_EDO = 2;
  localparam int GEO_SYNC_STAGES = 2;

  // register offsets
  localparam logic [7:0] ADDR_PIN_CONFIG_2 = 8'h02;
  localparam logic [7:0] ADDR_PIN_CONFIG_3 = 8'h03;
  localparam logic [7:0] ADDR_PIN_BHV_LOW = 8'h09;
  localparam logic [7:0] ADDR_PIN_BHV_HIGH = 8'h0A;
  localparam logic [7:0] ADDR_EDO_ENABLE = 8'h16;
  localparam logic [7:0] ADDR_OVH_MASK = 8'h31;
  localparam logic [7:0] ADDR_TERM_MASK = 8'h35;
  localparam logic [7:0] ADDR_EMASK_A = 8'h37;
  localparam logic [7:0] ADDR_EMASK_B = 8'h38;
  localparam logic [7:0] ADDR_HOST_TS2 = 8'hB9;
  localparam logic [7:0] ADDR_HOST_DS1 = 8'hBE;
  localparam logic [7:0] ADDR_PIN_STATUS = 8'hBF;
  localparam logic [7:0] ADDR_MGMT_TS2 = 8'hC1;
  localparam logic [7:0] ADDR_MGMT_DS1 = 8'hC6;

  // reset values
  localparam logic [7:0] RST_PIN_CONFIG_2 = 8'h40;
  localparam logic [7:0] RST_PIN_CONFIG_3 = 8'h00;
  localparam logic [7:0] RST_PIN_BHV = 8'h00;
  localparam logic [7:0] RST_EDO_ENABLE = 8'h00;
  localparam logic [7:0] RST_MASK = 8'h00;
  localparam logic [7:0] RST_ZERO = 8'h00;

  // field positions
  localparam int CFG2_BOOST0_BIT = 3;
  localparam int CFG3_CI_CLEAR_BIT = 5;
  localparam int EMASK_VOLT_BIT = 7;
  localparam int EMASK_OVERHEAT_PIN_BIT = 6;
  localparam int EMASK_FAN_BIT = 5;
  localparam logic [7:0] EMASK_ALL_IGNORE = 8'hEF;
  localparam int EDO_EN_LSB = 0;
  localparam int EDO_PIN_LSB = 4;
  localparam int TS2_OVH_LSB = 0;
  localparam int DS1_TERM_LSB = 4;
  localparam int DS1_CI_BIT = 7;
  localparam int OVH_MASK_LSB = 0;
  localparam int TERM_MASK_LSB = 4;
endpackage

// file: testbench/geo_board_model.sv
// board side of the open-drain pins: pull-ups plus external pull-downs
`timescale 1ns/10ps
module geo_board_model
  import geo_pkg::*;
(
  input wire logic [GEO_PINS-1:0] gpio_out,
  input wire logic [GEO_PINS-1:0] gpio_oe,
  input wire logic [GEO_PINS-1:0] ext_low,
  output logic [GEO_PINS-1:0] gpio_in
);
  // wired-and: a released line floats up, any party may pull it low
  assign gpio_in = ~ext_low & (~gpio_oe | gpio_out);
endmodule // geo_board_model

// file: testbench/geo_event_gpio_tb.sv
// self-checking bench for the event-driven general-purpose pin block
`timescale 1ns/10ps
module geo_event_gpio_tb
  import geo_pkg::*;
;
  logic ref_clk, rst_n, reg_wr, reg_rd, ci, pwr, intr, alrt, fan;
  logic [7:0] ext_low, gpio_in, gpio_out, gpio_oe, reg_addr, reg_wdata;
  logic [7:0] reg_rdata, cell_v, cell_lim, v;
  logic [1:0] ovh, term, latch_en, event_driven_output;
  logic [2:0] evt;
  int fails, total_checks, seed;

  geo_event_gpio geo_event_gpio_i (.ref_clk(ref_clk), .rst_n(rst_n),
    .gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .regulator_overheat_input(ovh), .bus_termination_input(term),
    .chassis_intrusion(ci), .voltage_event(evt[2]),
    .overtemp_event(evt[1]), .fan_fail_event(evt[0]),
    .event_latch_en(latch_en), .backup_cell_voltage(cell_v),
    .backup_cell_low_limit(cell_lim), .main_power_on(pwr),
    .int_out(intr), .alert_out(alrt), .fan_full_speed(fan),
    .edo_active(event_driven_output));
  geo_board_model geo_board_model_i (.gpio_out(gpio_out),
    .gpio_oe(gpio_oe), .ext_low(ext_low), .gpio_in(gpio_in));

  initial begin
    ref_clk = 0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  task automatic check(input string what, input logic [7:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask

  task automatic rchk(input string n, input logic [7:0] a, e);
    rd(a);
    check(n, v, e);
  endtask

  // synchronisers plus output registers need at most four edges
  task automatic settle;
    repeat (6) @(posedge ref_clk);
    #1;
  endtask

  // output pins read back what was written, input pins their assertion
  function automatic logic [7:0] exp_stat(input logic [7:0] d, p, s, x);
    return (d & s) | (~d & (x ^ p));
  endfunction

  initial begin
    repeat (100000) @(posedge ref_clk);
    fails++;
    give_verdict();
  end

  initial begin
    logic [7:0] lo, hi, st, xl, mk, d, p, ra[15];
    logic [1:0] pe;
    logic a;
    int j, e;
    seed = 32'h0bbd;
    {rst_n, reg_wr, reg_rd, ci, pwr} = '0;
    {ext_low, reg_addr, reg_wdata, ovh, term, latch_en, evt} = '0;
    cell_v = 8'hFF;
    cell_lim = 8'h80;
    fails = 0;
    total_checks = 0;
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    ra = '{8'h02, 8'h03, 8'h09, 8'h0A, 8'h16, 8'h31, 8'h35, 8'h37,
           8'h38, 8'hB9, 8'hBE, 8'hBF, 8'hC1, 8'hC6, 8'h55};
    foreach (ra[i]) rchk("reset", ra[i], (ra[i] == 8'h02) ? 8'h40 : 8'h00);
    wr(8'h55, 8'hA5);
    rchk("unmapped", 8'h55, 8'h00);
    // random direction, polarity, status, mask and board pulls
    for (int n = 0; n < 12; n++) begin
      lo = $random(seed);
      hi = $random(seed);
      st = $random(seed);
      xl = $random(seed);
      mk = $random(seed);
      for (int k = 0; k < 4; k++) begin
        d[k] = lo[2*k+1];
        p[k] = lo[2*k];
        d[k+4] = hi[2*k+1];
        p[k+4] = hi[2*k];
      end
      wr(8'h38, mk);
      wr(8'h09, lo);
      wr(8'h0A, hi);
      ext_low <= xl & ~d;
      wr(8'hBF, st);
      settle();
      check("pin drive", gpio_oe, d & (st ^ p));
      check("open drain", gpio_out, 8'h00);
      rchk("pin status", 8'hBF, exp_stat(d, p, st, xl & ~d));
      check("pin int", intr, |(exp_stat(d, p, st, xl) & ~d & ~mk));
    end
    // every pin-mask code of the event table, alternating outputs
    ext_low <= 8'h00;
    wr(8'h09, 8'h00);
    pe = $random(seed);
    wr(8'h0A, {5'h00, pe[1], 1'b0, pe[0]});
    wr(8'h16, 8'h03);
    for (int m = 0; m < 16; m++) begin
      j = $random(seed) & 3;
      e = m & 1;
      wr(e ? 8'h37 : 8'h38, 8'hEF);
      wr(e ? 8'h38 : 8'h37, {4'hE, 4'(m)});
      ext_low <= 8'(1 << j);
      settle();
      a = ~m[j];
      check("event out", event_driven_output, 2'(a) << e);
      check("event pin", gpio_oe[4+e], pe[e] ^ a);
      ext_low <= 8'h00;
      settle();
      check("event drop", event_driven_output, 2'b00);
    end
    // fan, temperature and voltage events, masked then latched
    wr(8'h38, 8'hEF);
    for (int k = 0; k < 3; k++) begin
      latch_en <= 2'b01;
      wr(8'h37, 8'h1F | (8'h20 << k));
      evt <= 3'(1 << k);
      @(posedge ref_clk) evt <= 3'b000;
      settle();
      check("event ignored", event_driven_output, 2'b00);
      wr(8'h37, 8'h1F);
      evt <= 3'(1 << k);
      @(posedge ref_clk) evt <= 3'b000;
      settle();
      check("event latched", event_driven_output, 2'b01);
      latch_en <= 2'b00;
      settle();
      check("latch released", event_driven_output, 2'b00);
    end
    // overheat and termination inputs, masks and fan boost
    wr(8'h31, 8'h03);
    wr(8'h35, 8'h30);
    ovh <= 2'b11;
    term <= 2'b11;
    settle();
    check("alert masked", alrt, 1'b0);
    check("no boost", fan, 1'b0);
    rchk("host ovh", 8'hB9, 8'h03);
    rchk("mgmt ovh", 8'hC1, 8'h03);
    rchk("host term", 8'hBE, 8'h30);
    rchk("mgmt term", 8'hC6, 8'h30);
    wr(8'h31, 8'h01);
    settle();
    check("alert ovh", alrt, 1'b1);
    wr(8'h31, 8'h03);
    wr(8'h35, 8'h10);
    settle();
    check("alert term", alrt, 1'b1);
    for (int k = 0; k < 4; k++) begin
      ovh <= k[1] ? 2'b01 : 2'b10;
      wr(8'h02, k[0] ? 8'h50 : 8'h48);
      settle();
      check("boost", fan, k[0] ^ k[1]);
    end
    {ovh, term} <= '0;
    // chassis intrusion: power gating, clear bit, dead backup cell
    wr(8'h09, 8'hAA);
    wr(8'h0A, 8'hAA);
    wr(8'h16, 8'h00);
    cell_v <= 8'h80 | 8'($random(seed));
    ci <= 1'b1;
    settle();
    rd(8'hBE);
    check("intrusion host", v[7], 1'b1);
    rd(8'hC6);
    check("intrusion mgmt", v[7], 1'b1);
    check("int unpowered", intr, 1'b0);
    pwr <= 1'b1;
    settle();
    check("int powered", intr, 1'b1);
    ci <= 1'b0;
    settle();
    check("int held", intr, 1'b1);
    wr(8'h03, 8'h20);
    wr(8'h03, 8'h00);
    settle();
    rd(8'hBE);
    check("intrusion clear", v[7], 1'b0);
    check("int clear", intr, 1'b0);
    cell_v <= 8'h7F & 8'($random(seed));
    ci <= 1'b1;
    settle();
    rd(8'hBE);
    check("cell low", v[7], 1'b0);
    give_verdict();
  end
endmodule // geo_event_gpio_tb
